// >>> hw/dopc_top.sv
// DAC output path control: registers, routing decode, event-started updates
//
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`include "dopc_map.svh"

// Summary of operation
// R1: Four channels exist and each can load a new code on its event input.
// R2: Each channel's switch bit sends the result to the pin or internally.
// R3: Each channel's amplifier bit decides if the output amplifier runs.
// R4: A channel with global and own enable 0 is stopped, both outputs off.
// R5: Running, amp 0, switch 0: amplifier stopped, pin gets through path.
// R6: Running, amp 0, switch 1: amplifier stopped, internal gets through.
// R7: Running, amp 1, switch 0: amplifier runs and drives the pin.
// R8: Running, amp 1, switch 1: amplifier runs, both outputs off.
// R9: Global enable 1 runs every channel with the same amp/switch decode.
// R10: Module-stop halts all conversions to save power.
// R11: Running is global enable or own enable, renewed on every write.
// R12: Reset clears all enables, amp and switch bits, so all outputs off.
module dopc_top
    import dopc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Event link start inputs
    input wire logic [3:0] evt_start,
    // Analog path controls
    output logic [3:0] chan_run,
    output logic [3:0] amp_run,
    output logic [3:0] ext_en,
    output logic [3:0] ext_amp_sel,
    output logic [3:0] int_en,
    output dopc_pkg::dopc_codes_t dac_code
);
    import dopc_pkg::*;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    // Returns {amp_run, ext_en, int_en} for one channel
    function automatic logic [2:0] route_decode(input logic run,
        input logic amp, input logic sw);
        logic [2:0] r;
        r = 3'h0;
        if (run) begin
            r[2] = amp; // R3
            r[1] = ~sw; // R2 R5 R7
            r[0] = ~amp & sw; // R6 R8
        end
        return r; // R4
    endfunction

    // Merges a write through byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    dopc_state_t q;
    dopc_state_t d;
    logic [3:0] evt_rise;
    logic [31:0] stat_word;
    logic [31:0] rd_mux;
    logic [31:0] wmerge;
    logic [2:0] ch_idx;
    logic [2:0] rt [4];

    // ****************************************************************
    // Per-channel routing
    // ****************************************************************
    // Running is a pure function of the live bits, so it follows any write
    assign chan_run = {4{q.gen}} | q.oe; // R9 R11
    generate
        for (genvar i = 0; i < 4; i++) begin : g_ch
            assign rt[i] = route_decode(chan_run[i], q.amp[i], q.sw[i]);
            assign amp_run[i] = rt[i][2];
            assign ext_en[i] = rt[i][1];
            assign int_en[i] = rt[i][0];
            // Amplifier output when it runs, otherwise the through path
            assign ext_amp_sel[i] = rt[i][2];
        end
    endgenerate

    // Event edge counts only once the filtered level rises
    assign evt_rise = q.s2 & q.s3 & ~q.filt; // R1

    // Bus outputs: first cycle of a request stalls, second answers
    assign waitrequest = (read | write) & (q.bus != DOPC_BUS_ACK);
    assign readdata = q.rdata;
    assign dac_code = q.code;

    // Status view of the block's own state
    always_comb begin
        stat_word = `DOPC_RST_WORD;
        stat_word[`DOPC_STAT_RUN_LSB +: 4] = chan_run;
        stat_word[`DOPC_STAT_AMP_LSB +: 4] = amp_run;
        stat_word[`DOPC_STAT_EXT_LSB +: 4] = ext_en;
        stat_word[`DOPC_STAT_INT_LSB +: 4] = int_en;
        stat_word[`DOPC_STAT_STOP_BIT] = q.stop;
    end

    // ****************************************************************
    // Read decode
    // ****************************************************************
    always_comb begin
        rd_mux = `DOPC_RST_WORD;
        ch_idx = address[4:2] - 3'h4;
        case (address)
            `DOPC_OFS_CTRL: begin
                rd_mux[`DOPC_CTRL_GEN_BIT] = q.gen;
                rd_mux[`DOPC_CTRL_OE_LSB +: 4] = q.oe;
                rd_mux[`DOPC_CTRL_EVS_LSB +: 4] = q.evs;
            end
            `DOPC_OFS_AMP: rd_mux[3:0] = q.amp;
            `DOPC_OFS_SW: rd_mux[3:0] = q.sw;
            `DOPC_OFS_STOP: rd_mux[0] = q.stop;
            `DOPC_OFS_STAT: rd_mux = stat_word;
            default: begin
                if (address >= `DOPC_OFS_DATA0 &&
                    address <= `DOPC_OFS_DATA3 && address[1:0] == 2'h0) begin
                    rd_mux[11:0] = q.data[ch_idx[1:0]];
                end
            end
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d = q;
        wmerge = be_merge(rd_mux, writedata, byteenable);
        // Three-stage sync; the level moves only when stages two and three agree
        d.s1 = evt_start;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.filt = (q.s2 & q.s3) | (q.filt & (q.s2 | q.s3));
        // Event-started conversions; none while module-stopped
        for (int i = 0; i < 4; i++) begin
            if (evt_rise[i] && chan_run[i] && !q.stop && q.evs[i]) begin
                d.code[i] = q.data[i]; // R1 R10
            end
        end
        case (q.bus)
            DOPC_BUS_IDLE: begin
                if (read || write) begin
                    d.bus = DOPC_BUS_ACK;
                    d.rdata = read ? rd_mux : q.rdata;
                end
            end
            DOPC_BUS_ACK: begin
                d.bus = DOPC_BUS_IDLE;
                if (write) begin
                    case (address)
                        `DOPC_OFS_CTRL: begin
                            d.gen = wmerge[`DOPC_CTRL_GEN_BIT]; // R11
                            d.oe = wmerge[`DOPC_CTRL_OE_LSB +: 4];
                            d.evs = wmerge[`DOPC_CTRL_EVS_LSB +: 4];
                        end
                        `DOPC_OFS_AMP: d.amp = wmerge[3:0]; // R3
                        `DOPC_OFS_SW: d.sw = wmerge[3:0]; // R2
                        `DOPC_OFS_STOP: d.stop = wmerge[0]; // R10
                        default: begin
                            if (address >= `DOPC_OFS_DATA0 &&
                                address <= `DOPC_OFS_DATA3 &&
                                address[1:0] == 2'h0) begin
                                d.data[ch_idx[1:0]] = wmerge[11:0];
                                // Direct update unless the channel waits, is stopped or module stop is set
                                if (chan_run[ch_idx[1:0]] && !q.stop &&
                                    !q.evs[ch_idx[1:0]]) begin
                                    d.code[ch_idx[1:0]] = wmerge[11:0];
                                end
                            end
                        end
                    endcase
                end
            end
            default: d.bus = DOPC_BUS_IDLE;
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Everything cleared but the bus phase, which loads idle, so every channel starts stopped and hi-Z
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0; // R12
            q.bus <= DOPC_BUS_IDLE;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Channels whose filtered event edge must load a new code
    logic [3:0] evt_arm;
    logic [47:0] arm_mask;
    assign evt_arm = evt_rise & chan_run & q.evs;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            arm_mask[i*12 +: 12] = {12{evt_arm[i]}};
        end
    end

    sequence evt_arm_s;
        (|evt_arm) && !q.stop;
    endsequence

    // Armed channels take the data word held when the edge was seen
    sequence code_load_s;
        (dac_code & $past(arm_mask)) == ($past(q.data) & $past(arm_mask));
    endsequence

    stopped_hiz_a: assert property ( // R4
        ((~chan_run) & (ext_en | int_en | amp_run)) == 4'h0)
        else $error("stopped channel drives an output");
    through_pin_a: assert property ( // R5
        ((chan_run & ~q.amp & ~q.sw) &
        ~(ext_en & ~ext_amp_sel & ~int_en & ~amp_run)) == 4'h0)
        else $error("through path not on pin");
    through_int_a: assert property ( // R6
        ((chan_run & ~q.amp & q.sw) & ~(int_en & ~ext_en & ~amp_run))
        == 4'h0) else $error("through path not internal");
    amp_pin_a: assert property ( // R7
        ((chan_run & q.amp & ~q.sw) &
        ~(ext_en & ext_amp_sel & amp_run & ~int_en)) == 4'h0)
        else $error("amplifier not driving pin");
    amp_hiz_a: assert property ( // R8
        ((chan_run & q.amp & q.sw) & ~(amp_run & ~ext_en & ~int_en))
        == 4'h0) else $error("amp with switch set not hi-Z");
    global_run_a: assert property ( // R9
        q.gen |-> chan_run == 4'hF) else $error("global enable not running");
    ctrl_write_a: assert property ( // R11
        (write && !waitrequest && address == `DOPC_OFS_CTRL && byteenable[0])
        |=> chan_run == ($past(writedata[0]) ? 4'hF :
        $past(writedata[7:4]))) else $error("run not renewed by write");
    reset_clear_a: assert property ( // R12
        $past(sys_rst) |-> chan_run == 4'h0 && ext_en == 4'h0 &&
        int_en == 4'h0) else $error("outputs not off after reset");
    stop_hold_a: assert property ( // R10
        q.stop |=> $stable(dac_code)) else $error("code changed in stop");
    evt_load_a: assert property ( // R1
        evt_arm_s |=> code_load_s)
        else $error("event did not start conversion");
    bus_answer_a: assert property (
        (read || write) |-> ##[0:1] !waitrequest)
        else $error("bus answer late");

endmodule

// >>> hw/dopc_map.svh
// Register offsets, field positions and reset values of the DAC path control
`ifndef DOPC_MAP_SVH
`define DOPC_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DOPC_OFS_CTRL 6'h00
`define DOPC_OFS_AMP 6'h04
`define DOPC_OFS_SW 6'h08
`define DOPC_OFS_STOP 6'h0C
`define DOPC_OFS_DATA0 6'h10
`define DOPC_OFS_DATA3 6'h1C
`define DOPC_OFS_STAT 6'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define DOPC_CTRL_GEN_BIT 0
`define DOPC_CTRL_OE_LSB 4
`define DOPC_CTRL_EVS_LSB 8
`define DOPC_STAT_RUN_LSB 0
`define DOPC_STAT_AMP_LSB 4
`define DOPC_STAT_EXT_LSB 8
`define DOPC_STAT_INT_LSB 12
`define DOPC_STAT_STOP_BIT 16

// ****************************************************************
// Reset values
// ****************************************************************
`define DOPC_RST_BITS4 4'h0
`define DOPC_RST_CODE 12'h000
`define DOPC_RST_WORD 32'h0000_0000

`endif

// >>> hw/dopc_pkg.sv
// Types shared by the DAC output path control
package dopc_pkg;

    // Bus slave phase, one-hot
    typedef enum logic [1:0] {
        DOPC_BUS_IDLE = 2'b01,
        DOPC_BUS_ACK = 2'b10
    } dopc_bus_t;

    typedef logic [3:0][11:0] dopc_codes_t;

    // Whole state of the block
    typedef struct packed {
        dopc_bus_t bus;
        logic [31:0] rdata;
        logic gen;
        logic [3:0] oe;
        logic [3:0] evs;
        logic [3:0] amp;
        logic [3:0] sw;
        logic stop;
        dopc_codes_t data;
        dopc_codes_t code;
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] filt;
    } dopc_state_t;

endpackage

// >>> tb/dopc_far_side.sv
// Far-side model: what the pin and the internal consumers see per channel
module dopc_far_side (
    // Path controls from the block
    input wire logic [3:0] ext_en,
    input wire logic [3:0] ext_amp_sel,
    input wire logic [3:0] int_en,
    // Seen source per channel: pin 0 hi-Z, 1 through, 2 amplifier; internal 1 when enabled
    output logic [7:0] pin_src,
    output logic [3:0] int_src
);
    timeunit 1ns;
    timeprecision 1ps;
    // A pin that is not driven floats, so no source is seen there
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_src[2*i +: 2] = !ext_en[i] ? 2'h0 :
                (ext_amp_sel[i] ? 2'h2 : 2'h1);
        end
        int_src = int_en;
    end
endmodule

// >>> tb/tb_dac_output_path_control.sv
// Self-checking bench of the DAC output path control
`define CHK(a, b) begin \
    samples_checked++; \
    if ((a) !== (b)) begin \
        failures++; \
        $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); \
    end \
end
module tb_dac_output_path_control;
    timeunit 1ns;
    timeprecision 1ps;
    import dopc_pkg::*;
    logic clk = 0, sys_rst = 1, read = 0, write = 0;
    logic [5:0] address = 6'h00;
    logic [3:0] byteenable = 4'hF, evt_start = 4'h0;
    logic [31:0] writedata = 32'h0000_0000, readdata, q;
    logic waitrequest;
    logic [3:0] chan_run, amp_run, ext_en, ext_amp_sel, int_en, int_src;
    logic [7:0] pin_src, pe;
    dopc_codes_t dac_code;
    int failures = 0, samples_checked = 0, seed = 81, cyc = 0;
    int g, oe, amp, sw, r, c;
    int exp_code[$];
    dopc_top dopc_top_i (.clk(clk), .sys_rst(sys_rst), .address(address),
        .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .evt_start(evt_start), .chan_run(chan_run), .amp_run(amp_run),
        .ext_en(ext_en), .ext_amp_sel(ext_amp_sel), .int_en(int_en),
        .dac_code(dac_code));
    dopc_far_side dopc_far_side_i (.ext_en(ext_en), .ext_amp_sel(ext_amp_sel),
        .int_en(int_en), .pin_src(pin_src), .int_src(int_src));
    // ************************************************************
    // Clock, timeout and verdict
    // ************************************************************
    always #2.5 clk = ~clk;
    // Ceiling well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            results;
        end
    end
    task automatic results;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One Avalon transfer; the answer is taken at the edge that sees it
    task automatic bus(input logic w, input logic [5:0] a,
        input logic [31:0] d, output logic [31:0] rd);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        // No own limit: only the bench timeout ends a hung wait
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    // Model of routing from the enable bits, then compare ports and status
    task automatic check_paths;
        r = g ? 15 : oe;
        pe = 8'h00;
        for (int i = 0; i < 4; i++) begin
            if (r[i] && !sw[i]) pe[2*i +: 2] = amp[i] ? 2'd2 : 2'd1;
        end
        @(negedge clk);
        `CHK(chan_run, 4'(r))
        `CHK(amp_run, 4'(r & amp))
        `CHK(pin_src, pe)
        `CHK(int_src, 4'(r & ~amp & sw))
        bus(0, `DOPC_OFS_STAT, 0, q);
        `CHK(q[15:0], {4'(r & ~amp & sw), 4'(r & ~sw), 4'(r & amp),
            4'(r)})
    endtask
    // Event start on one channel, with the filter's settle time after it
    task automatic pulse(input int ch);
        @(posedge clk);
        evt_start[ch] <= 1'b1;
        repeat (6) @(posedge clk);
        evt_start[ch] <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        g = 0; oe = 0; amp = 0; sw = 0;
        check_paths;
        for (int a = 0; a < 12; a += 4) begin
            bus(0, 6'(a), 0, q);
            `CHK(q, 32'h0000_0000)
        end
        bus(0, 6'h3C, 0, q);
        `CHK(q, 32'h0000_0000)
        // Random enable, amplifier and switch settings cover every decode row
        for (int k = 0; k < 160; k++) begin
            g = $random(seed) & 1;
            oe = $random(seed) & 15;
            amp = $random(seed) & 15;
            sw = $random(seed) & 15;
            bus(1, `DOPC_OFS_CTRL, 32'(g | (oe << 4)), q);
            bus(1, `DOPC_OFS_AMP, 32'(amp), q);
            bus(1, `DOPC_OFS_SW, 32'(sw), q);
            check_paths;
        end
        // Event-started loads: a data write alone must not reach the code
        bus(1, `DOPC_OFS_CTRL, 32'h0000_0F01, q);
        for (int ch = 0; ch < 4; ch++) begin
            c = $random(seed) & 12'hFFF;
            exp_code.push_back(c);
            bus(1, 6'(`DOPC_OFS_DATA0 + 4 * ch), 32'(c), q);
            @(negedge clk);
            `CHK(dac_code[ch], 12'h000)
            pulse(ch);
            `CHK(dac_code[ch], 12'(exp_code[ch]))
        end
        // Module stop: events are ignored and the code stays put
        bus(1, `DOPC_OFS_STOP, 32'h0000_0001, q);
        bus(0, `DOPC_OFS_STAT, 0, q);
        `CHK(q[16], 1'b1)
        bus(1, `DOPC_OFS_DATA0, 32'(~exp_code[0] & 12'hFFF), q);
        pulse(0);
        `CHK(dac_code[0], 12'(exp_code[0]))
        @(posedge clk);
        sys_rst <= 1'b1;
        @(negedge clk);
        `CHK(chan_run | int_en | ext_en, 4'h0)
        results;
    end
endmodule
